// [cpcr_bank.v]
// Purpose: clock and power control register bank on an AXI4-Lite slave
// Assumes: one aligned 32-bit word per byte-wide register, data in bits 7:0
// Notes:   unmapped addresses answer SLVERR, reads of them return zero
//
// Added by the designer: the AXI4-Lite register port.
`include "cpcr_regs.vh"

// Behaviour
// - obs clock bit one powers driver down
// - analog clock receiver off while bit set
// - div-three bit divides oscillator by three
// - div-two bit: zero full rate, one half
// - bypass zero: converter clock from PLL
// - bypass one: converters clocked by external clock
// - bias bit seven one powers bias down
// - delay line bit zero enables, one bypasses
module cpcr_bank #(
    parameter AW = 12
) (
    input  wire          i_core_clk,
    input  wire          i_srst,
    // axi4-lite write address
    input  wire [AW-1:0] i_axi_awaddr,
    input  wire          i_axi_awvalid,
    output wire          o_axi_awready,
    // axi4-lite write data
    input  wire [31:0]   i_axi_wdata,
    input  wire [3:0]    i_axi_wstrb,
    input  wire          i_axi_wvalid,
    output wire          o_axi_wready,
    // axi4-lite write response
    output wire [1:0]    o_axi_bresp,
    output wire          o_axi_bvalid,
    input  wire          i_axi_bready,
    // axi4-lite read address
    input  wire [AW-1:0] i_axi_araddr,
    input  wire          i_axi_arvalid,
    output wire          o_axi_arready,
    // axi4-lite read data
    output wire [31:0]   o_axi_rdata,
    output wire [1:0]    o_axi_rresp,
    output wire          o_axi_rvalid,
    input  wire          i_axi_rready,
    // analog and clocking controls
    output wire          o_obs_clock_driver_off,
    output wire          o_core1_power_off,
    output wire          o_core0_power_off,
    output wire          o_analog_clock_rx_off,
    output wire          o_pll_div_three_en,
    output wire          o_pll_div_two_en,
    output wire          o_pll_bypass,
    output wire          o_pll_active,
    output wire          o_bias_off,
    output wire          o_delay_line_off,
    output wire          o_delay_line_power_b,
    output wire          o_delay_line_power_a,
    output wire [1:0]    o_loop_converter_setting,
    output wire          o_loop_search_mode,
    output wire [1:0]    o_loop_search_direction,
    output wire          o_loop_enable,
    output wire          o_conv_clk_tick
);

    // register storage, only implemented bits ever become one
    reg  [7:0]    obs_q;
    reg  [7:0]    pwr_q;
    reg  [7:0]    aclk_q;
    reg  [7:0]    div_q;
    reg  [7:0]    byp_q;
    reg  [7:0]    bias_q;
    reg  [7:0]    dlp_q;
    reg  [7:0]    dlc_q;

    // derived state, registered so outputs come from flops
    reg           pll_active_q;
    reg  [2:0]    ratio_q;
    reg           conv_run_q;

    // axi handshake state
    reg           awready_q;
    reg           wready_q;
    reg           aw_held_q;
    reg           w_held_q;
    reg  [AW-1:0] aw_addr_q;
    reg  [7:0]    w_data_q;
    reg           w_lane0_q;
    reg           bvalid_q;
    reg  [1:0]    bresp_q;
    reg           arready_q;
    reg           rvalid_q;
    reg  [7:0]    rdata_q;
    reg  [1:0]    rresp_q;

    wire [7:0]    wr_idx;
    wire [7:0]    rd_idx;
    wire          wr_go;
    reg           wr_hit;
    reg           rd_hit;
    reg  [7:0]    rd_val;
    wire [7:0]    stat_val;
    wire          conv_tick;

    // word index, low two address bits ignored as the port is word wide
    assign wr_idx = aw_addr_q[9:2];
    assign rd_idx = i_axi_araddr[9:2];

    // a write completes once both halves are held and no response waits
    assign wr_go = aw_held_q && w_held_q && !bvalid_q;

    // write decode, anything outside the map is an error
    always @* begin
        wr_hit = 1'b0;
        if (aw_addr_q[AW-1:10] == {(AW-10){1'b0}}) begin
            case (wr_idx)
                `CPCR_IDX_OBS,  `CPCR_IDX_PWR,
                `CPCR_IDX_ACLK, `CPCR_IDX_DIV,
                `CPCR_IDX_BYP,  `CPCR_IDX_BIAS,
                `CPCR_IDX_DLP,  `CPCR_IDX_DLC,
                `CPCR_IDX_STAT: wr_hit = 1'b1;
                default:        wr_hit = 1'b0;
            endcase
        end
    end

    // write address channel, held until the response is accepted
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b0;
            aw_addr_q <= {AW{1'b0}};
        end else if (i_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            aw_addr_q <= i_axi_awaddr;
        end else if (bvalid_q && i_axi_bready) begin
            awready_q <= 1'b1;
            aw_held_q <= 1'b0;
        end else if (!aw_held_q) begin
            awready_q <= 1'b1;
        end
    end

    // write data channel, either order against the address
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            wready_q  <= 1'b0;
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (i_axi_wvalid && wready_q) begin
            wready_q  <= 1'b0;
            w_held_q  <= 1'b1;
            w_data_q  <= i_axi_wdata[7:0];
            w_lane0_q <= i_axi_wstrb[0];
        end else if (bvalid_q && i_axi_bready) begin
            wready_q  <= 1'b1;
            w_held_q  <= 1'b0;
        end else if (!w_held_q) begin
            wready_q  <= 1'b1;
        end
    end

    // write response, raised in the cycle the registers update
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `CPCR_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `CPCR_RESP_OKAY : `CPCR_RESP_SLVERR;
        end else if (bvalid_q && i_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // register update; masks drop reserved bits so they stay zero
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            obs_q  <= `CPCR_RST_OBS;
            pwr_q  <= `CPCR_RST_PWR;
            aclk_q <= `CPCR_RST_ACLK;
            div_q  <= `CPCR_RST_DIV;
            byp_q  <= `CPCR_RST_BYP;
            bias_q <= `CPCR_RST_BIAS;
            dlp_q  <= `CPCR_RST_DLP;
            dlc_q  <= `CPCR_RST_DLC;
        end else if (wr_go && wr_hit && w_lane0_q) begin
            case (wr_idx)
                `CPCR_IDX_OBS:  obs_q  <= w_data_q & `CPCR_MSK_OBS;
                `CPCR_IDX_PWR:  pwr_q  <= w_data_q & `CPCR_MSK_PWR;
                `CPCR_IDX_ACLK: aclk_q <= w_data_q & `CPCR_MSK_ACLK;
                `CPCR_IDX_DIV:  div_q  <= w_data_q & `CPCR_MSK_DIV;
                `CPCR_IDX_BYP:  byp_q  <= w_data_q & `CPCR_MSK_BYP;
                `CPCR_IDX_BIAS: bias_q <= w_data_q & `CPCR_MSK_BIAS;
                `CPCR_IDX_DLP:  dlp_q  <= w_data_q & `CPCR_MSK_DLP;
                `CPCR_IDX_DLC:  dlc_q  <= w_data_q & `CPCR_MSK_DLC;
                default:        obs_q  <= obs_q;
            endcase
        end
    end

    // status view of the block's own clocking state
    assign stat_val = {3'h0, ratio_q, (dlp_q == 8'h00), pll_active_q};

    // read decode; stored values already hold zero in reserved bits
    always @* begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        if (i_axi_araddr[AW-1:10] != {(AW-10){1'b0}}) begin
            rd_hit = 1'b0;
        end else begin
            case (rd_idx)
                `CPCR_IDX_OBS:  rd_val = obs_q;
                `CPCR_IDX_PWR:  rd_val = pwr_q;
                `CPCR_IDX_ACLK: rd_val = aclk_q;
                `CPCR_IDX_DIV:  rd_val = div_q;
                `CPCR_IDX_BYP:  rd_val = byp_q;
                `CPCR_IDX_BIAS: rd_val = bias_q;
                `CPCR_IDX_DLP:  rd_val = dlp_q;
                `CPCR_IDX_DLC:  rd_val = dlc_q;
                `CPCR_IDX_STAT: rd_val = stat_val;
                default:        rd_hit = 1'b0;
            endcase
        end
    end

    // read channel, data returned one cycle after the address is taken
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 8'h00;
            rresp_q   <= `CPCR_RESP_OKAY;
        end else if (i_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_val;
            rresp_q   <= rd_hit ? `CPCR_RESP_OKAY : `CPCR_RESP_SLVERR;
        end else if (rvalid_q && i_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // converter clock source and divide ratio
    // both divide bits together give divide by six; hardware never
    // sees a half-programmed ratio as it is resampled each cycle
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            pll_active_q <= 1'b1;
            ratio_q      <= 3'h1;
            conv_run_q   <= 1'b0;
        end else begin
            pll_active_q <= !byp_q[`CPCR_B_BYPASS];
            if (byp_q[`CPCR_B_BYPASS]) begin
                ratio_q <= 3'h1;
            end else begin
                case (div_q[1:0])
                    2'h1:    ratio_q <= 3'h2;
                    2'h2:    ratio_q <= 3'h3;
                    2'h3:    ratio_q <= 3'h6;
                    default: ratio_q <= 3'h1;
                endcase
            end
            // converter ticks stop from the second cycle after the receiver is switched off
            conv_run_q <= !aclk_q[`CPCR_B_ACLK_OFF];
        end
    end

    // converter clock enable pulses
    cpcr_clk_div #(
        .W (3)
    ) u_div (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_run      (conv_run_q),
        .i_ratio    (ratio_q),
        .o_tick     (conv_tick)
    );

    // bus outputs
    assign o_axi_awready = awready_q;
    assign o_axi_wready  = wready_q;
    assign o_axi_bvalid  = bvalid_q;
    assign o_axi_bresp   = bresp_q;
    assign o_axi_arready = arready_q;
    assign o_axi_rvalid  = rvalid_q;
    assign o_axi_rresp   = rresp_q;
    assign o_axi_rdata   = {24'h000000, rdata_q};

    // control outputs straight from flops: the register flops, pll_active_q and the divider tick
    assign o_obs_clock_driver_off   = obs_q[`CPCR_B_OBS_OFF];
    assign o_core1_power_off        = pwr_q[`CPCR_B_CORE1_OFF];
    assign o_core0_power_off        = pwr_q[`CPCR_B_CORE0_OFF];
    assign o_analog_clock_rx_off    = aclk_q[`CPCR_B_ACLK_OFF];
    assign o_pll_div_three_en       = div_q[`CPCR_B_DIV3];
    assign o_pll_div_two_en         = div_q[`CPCR_B_DIV2];
    assign o_pll_bypass             = byp_q[`CPCR_B_BYPASS];
    assign o_pll_active             = pll_active_q;
    assign o_bias_off               = bias_q[`CPCR_B_BIAS_OFF];
    assign o_delay_line_off         = dlp_q[`CPCR_B_DL_OFF];
    assign o_delay_line_power_b     = dlp_q[`CPCR_B_DLP_B];
    assign o_delay_line_power_a     = dlp_q[`CPCR_B_DLP_A];
    assign o_loop_converter_setting = dlc_q[`CPCR_F_CONV_HI:`CPCR_F_CONV_LO];
    assign o_loop_search_mode       = dlc_q[`CPCR_B_SEARCH_MODE];
    assign o_loop_search_direction  = dlc_q[`CPCR_F_DIR_HI:`CPCR_F_DIR_LO];
    assign o_loop_enable            = dlc_q[`CPCR_B_LOOP_EN];
    assign o_conv_clk_tick          = conv_tick;

endmodule // cpcr_bank

// [cpcr_bank_properties.sv]
// Purpose: port checker for the clock and power control register bank
// Assumes: bound to every cpcr_bank instance
// Notes:   the bypass check waits eight cycles so an old ratio has wrapped; the receiver check waits three
module cpcr_bank_properties (
    input wire logic        i_core_clk,
    input wire logic        i_srst,
    input wire logic        i_axi_arvalid,
    input wire logic        o_axi_arready,
    input wire logic        o_axi_awready,
    input wire logic        o_axi_wready,
    input wire logic [1:0]  o_axi_bresp,
    input wire logic        o_axi_bvalid,
    input wire logic        i_axi_bready,
    input wire logic [31:0] o_axi_rdata,
    input wire logic        o_axi_rvalid,
    input wire logic        i_axi_rready,
    input wire logic        o_obs_clock_driver_off,
    input wire logic        o_analog_clock_rx_off,
    input wire logic        o_pll_bypass,
    input wire logic        o_pll_active,
    input wire logic        o_conv_clk_tick
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // bus answers stand until taken
    a_bresp_holds: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
        else $error("write response dropped or changed before bready");
    a_rdata_holds: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
        else $error("read data dropped or changed before rready");
    a_read_answer: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
        else $error("read data not valid one cycle after address taken");
    a_busy_refuse: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
        else $error("write channel ready while response pending");
    a_upper_zero: assert property (o_axi_rvalid |-> o_axi_rdata[31:8] == 24'h000000)
        else $error("read data bits above the byte not zero");
    // driver control moves only with a completed write; pll active trails bypass by a cycle
    a_obs_on_write: assert property ($changed(o_obs_clock_driver_off) |-> $rose(o_axi_bvalid))
        else $error("driver control changed without a write");
    a_pll_follow: assert property (o_pll_active == !$past(o_pll_bypass))
        else $error("pll active not the inverse of bypass");
    // converter clock enable follows receiver power and bypass
    a_rx_quiet: assert property (o_analog_clock_rx_off [*3] |-> !o_conv_clk_tick)
        else $error("tick while clock receiver powered down");
    a_bypass_full: assert property ((o_pll_bypass && !o_analog_clock_rx_off) [*8] |-> o_conv_clk_tick)
        else $error("bypass does not tick every cycle");

    c_write: cover property ($rose(o_axi_bvalid));
    c_read: cover property (o_axi_rvalid && i_axi_rready);
    c_tick: cover property (o_conv_clk_tick ##1 !o_conv_clk_tick);
endmodule // cpcr_bank_properties

bind cpcr_bank cpcr_bank_properties cpcr_bank_properties_i (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_axi_arvalid(i_axi_arvalid),
    .o_axi_arready(o_axi_arready),
    .o_axi_awready(o_axi_awready),
    .o_axi_wready(o_axi_wready),
    .o_axi_bresp(o_axi_bresp),
    .o_axi_bvalid(o_axi_bvalid),
    .i_axi_bready(i_axi_bready),
    .o_axi_rdata(o_axi_rdata),
    .o_axi_rvalid(o_axi_rvalid),
    .i_axi_rready(i_axi_rready),
    .o_obs_clock_driver_off(o_obs_clock_driver_off),
    .o_analog_clock_rx_off(o_analog_clock_rx_off),
    .o_pll_bypass(o_pll_bypass),
    .o_pll_active(o_pll_active),
    .o_conv_clk_tick(o_conv_clk_tick)
);

// [cpcr_bank_tb.sv]
// Purpose: self-checking bench for the clock and power control register bank
// Assumes: byte address is four times the register index
// Notes:   control outputs are compared against a shadow of the registers
`include "cpcr_regs.vh"
module cpcr_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] rst;
        logic [7:0] wd;
        logic [7:0] rd;
    } cpcr_row_t;
    // index, reset value, data written, data read back
    cpcr_row_t rows [8] = '{'{8'h8F, 8'h00, 8'hFF, 8'h01}, '{8'h90, 8'h03, 8'hFE, 8'h02},
                          '{8'h91, 8'h01, 8'hFE, 8'h00}, '{8'h94, 8'h00, 8'hFF, 8'h03},
                          '{8'h95, 8'h00, 8'hFF, 8'h01}, '{8'h9A, 8'h00, 8'hFF, 8'h80},
                          '{8'hC0, 8'h31, 8'hCE, 8'h00}, '{8'hC1, 8'h70, 8'h4F, 8'h49}};
    logic [7:0]  sh [8];
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        fast = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    wire         awready;
    wire         wready;
    wire         bvalid;
    wire         arready;
    wire         rvalid;
    wire         tick;
    wire [1:0]   bresp;
    wire [1:0]   rresp;
    wire [31:0]  rdata;
    wire [17:0]  outs;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    cpcr_bank cpcr_bank_i (
        .i_core_clk(core_clk), .i_srst(srst),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .o_obs_clock_driver_off(outs[17]), .o_core1_power_off(outs[16]), .o_core0_power_off(outs[15]),
        .o_analog_clock_rx_off(outs[14]), .o_pll_div_three_en(outs[13]), .o_pll_div_two_en(outs[12]),
        .o_pll_bypass(outs[11]), .o_pll_active(outs[10]), .o_bias_off(outs[9]),
        .o_delay_line_off(outs[8]), .o_delay_line_power_b(outs[7]), .o_delay_line_power_a(outs[6]),
        .o_loop_converter_setting(outs[5:4]), .o_loop_search_mode(outs[3]),
        .o_loop_search_direction(outs[2:1]), .o_loop_enable(outs[0]), .o_conv_clk_tick(tick)
    );

    // clock and hang guard; the run needs well under 2000 cycles
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end

    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // control outputs as the shadow registers say they should stand
    function automatic logic [17:0] exp_outs();
        return {sh[0][0], sh[1][1:0], sh[2][0], sh[3][1:0], sh[4][0], ~sh[4][0], sh[5][7], sh[6][0],
                sh[6][5:4], sh[7][7:3], sh[7][0]};
    endfunction

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // upper data bits are set on purpose: the bank must ignore them
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'hFFFFFF, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= fast;
        forever begin
            @(posedge core_clk);
            if (bvalid && bready) break;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= fast;
        forever begin
            @(posedge core_clk);
            if (rvalid && rready) break;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence: table rows, then refusals, divider, second reset
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        foreach (rows[i]) sh[i] = rows[i].rst;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            axi_read(adr(rows[i].idx), d, r);
            chk_val("reset value", {24'h0, rows[i].rst}, d);
            chk_resp("read resp", `CPCR_RESP_OKAY, r);
            axi_write(adr(rows[i].idx), rows[i].wd, 4'hF, r);
            chk_resp("write resp", `CPCR_RESP_OKAY, r);
            axi_read(adr(rows[i].idx), d, r);
            chk_val("readback", {24'h0, rows[i].rd}, d);
            sh[i] = rows[i].rd;
            chk_val("controls", {14'h0, exp_outs()}, {14'h0, outs});
        end
        axi_read(adr(8'hC5), d, r);
        chk_val("status", 32'h00000006, d);
        fast = 1'b0;
        axi_write(adr(8'h92), 8'hFF, 4'hF, r);
        chk_resp("unmapped write", `CPCR_RESP_SLVERR, r);
        axi_read(adr(8'h92), d, r);
        chk_resp("unmapped read", `CPCR_RESP_SLVERR, r);
        chk_val("unmapped data", 32'h0, d);
        axi_write(12'h400 | adr(8'h8F), 8'h00, 4'hF, r);
        chk_resp("alias write", `CPCR_RESP_SLVERR, r);
        axi_write(adr(8'h8F), 8'h00, 4'h0, r);
        chk_resp("no strobe write", `CPCR_RESP_OKAY, r);
        axi_write(adr(8'hC5), 8'h00, 4'hF, r);
        axi_read(adr(8'h8F), d, r);
        chk_val("driver kept", 32'h1, d);
        chk_val("controls", {14'h0, exp_outs()}, {14'h0, outs});
        fast = 1'b1;
        // divider: 60 cycles hold a whole number of periods of 1, 2, 3 and 6
        axi_write(adr(8'h95), 8'h00, 4'hF, r);
        for (int k = 0; k < 6; k++) begin
            if (k < 4) axi_write(adr(8'h94), 8'(k), 4'hF, r);
            if (k == 4) axi_write(adr(8'h95), 8'h01, 4'hF, r);
            if (k == 5) axi_write(adr(8'h91), 8'h01, 4'hF, r);
            repeat (12) @(posedge core_clk);
            n = 0;
            repeat (60) begin
                @(posedge core_clk);
                n += (tick === 1'b0) ? 0 : 1;
            end
            chk_val("tick count", (k == 5) ? 0 : (k == 3) ? 10 : (k == 4) ? 60 : 60 / (k + 1), n);
        end
        // reset in mid-run brings every control back to its reset level
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        foreach (rows[i]) sh[i] = rows[i].rst;
        axi_read(adr(8'hC1), d, r);
        chk_val("second reset", 32'h70, d);
        chk_val("controls", {14'h0, exp_outs()}, {14'h0, outs});
        complete_run();
    end
endmodule // cpcr_bank_tb

// [cpcr_clk_div.v]
// Purpose: converter clock enable generator, divide by a run-time ratio
// Assumes: ratio of 1 gives a tick on every core clock
// Notes:   a ratio change takes effect at the next wrap of the counter
module cpcr_clk_div #(
    parameter W = 3
) (
    input  wire         i_core_clk,
    input  wire         i_srst,
    input  wire         i_run,
    input  wire [W-1:0] i_ratio,
    output wire         o_tick
);

    reg [W-1:0] cnt_q;
    reg         tick_q;

    // count ratio-1 down to zero, pulse once per period
    always @(posedge i_core_clk) begin
        if (i_srst || !i_run) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q == {W{1'b0}}) begin
            cnt_q  <= i_ratio - {{(W-1){1'b0}}, 1'b1};
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            tick_q <= 1'b0;
        end
    end

    assign o_tick = tick_q;

endmodule // cpcr_clk_div

// [cpcr_regs.vh]
// Purpose: constants for the clock and power control register bank
// Assumes: register index = byte address / 4 on the AXI4-Lite port
// Notes:   masks list the implemented bits of the writable registers; their other bits read as zero
`ifndef CPCR_REGS_VH
`define CPCR_REGS_VH

// register indices
`define CPCR_IDX_OBS        8'h8F
`define CPCR_IDX_PWR        8'h90
`define CPCR_IDX_ACLK       8'h91
`define CPCR_IDX_DIV        8'h94
`define CPCR_IDX_BYP        8'h95
`define CPCR_IDX_BIAS       8'h9A
`define CPCR_IDX_DLP        8'hC0
`define CPCR_IDX_DLC        8'hC1
`define CPCR_IDX_STAT       8'hC5

// reset values
`define CPCR_RST_OBS        8'h00
`define CPCR_RST_PWR        8'h03
`define CPCR_RST_ACLK       8'h01
`define CPCR_RST_DIV        8'h00
`define CPCR_RST_BYP        8'h00
`define CPCR_RST_BIAS       8'h00
`define CPCR_RST_DLP        8'h31
`define CPCR_RST_DLC        8'h70

// writable bit masks
`define CPCR_MSK_OBS        8'h01
`define CPCR_MSK_PWR        8'h03
`define CPCR_MSK_ACLK       8'h01
`define CPCR_MSK_DIV        8'h03
`define CPCR_MSK_BYP        8'h01
`define CPCR_MSK_BIAS       8'h80
`define CPCR_MSK_DLP        8'h31
`define CPCR_MSK_DLC        8'hF9

// field positions
`define CPCR_B_OBS_OFF      0
`define CPCR_B_CORE1_OFF    1
`define CPCR_B_CORE0_OFF    0
`define CPCR_B_ACLK_OFF     0
`define CPCR_B_DIV3         1
`define CPCR_B_DIV2         0
`define CPCR_B_BYPASS       0
`define CPCR_B_BIAS_OFF     7
`define CPCR_B_DLP_B        5
`define CPCR_B_DLP_A        4
`define CPCR_B_DL_OFF       0
`define CPCR_F_CONV_HI      7
`define CPCR_F_CONV_LO      6
`define CPCR_B_SEARCH_MODE  5
`define CPCR_F_DIR_HI       4
`define CPCR_F_DIR_LO       3
`define CPCR_B_LOOP_EN      0

// bus responses
`define CPCR_RESP_OKAY      2'h0
`define CPCR_RESP_SLVERR    2'h2

`endif
